// ==== ca_tick_gen.sv ====
// counter clock tick generator: selectable prescale of the system clock, or a synchronised external source edge
`timescale 1ns/10ps
module ca_tick_gen
  import ca_wdt_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clk_sel,
  input  wire logic       ext_tick,
  output logic            tick
);

  typedef struct packed {
    logic [3:0] div;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_s3;
  } tick_st_t;

  tick_st_t st_q;
  tick_st_t st_d;
  logic     last;

  always_comb begin
    st_d        = st_q;
    st_d.ext_s1 = ext_tick;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_s3 = st_q.ext_s2;
    last        = (clk_sel == SEL_DIV4) ? (st_q.div == DIV4_LAST)
                                        : (st_q.div == DIV12_LAST);
    st_d.div    = last ? '0 : st_q.div + 4'h1;
    case (clk_sel)
      SEL_DIV12: tick = (st_q.div == DIV12_LAST);
      SEL_DIV4:  tick = (st_q.div == DIV4_LAST);
      SEL_SYS:   tick = 1'b1;
      // external source edge, synchronised before use
      SEL_EXT:   tick = st_q.ext_s2 & ~st_q.ext_s3;
      default:   tick = (st_q.div == DIV12_LAST);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : ca_tick_gen

// ==== ca_watchdog.sv ====
// counter array with module five in watchdog mode, AXI4-Lite register slave
// Notes on behaviour
// - enable bit makes module five the watchdog
// - watchdog enabled after every reset
// - counter forced running; run writes ineffective
// - run bit reads zero unless software set
// - counter byte writes ignored while enabled
// - clock select and idle bit frozen
// - module five forced software timer, writes ignored
// - low overflow with high match resets
// - high compare write loads counter high plus offset
// - writing one to match flag forces reset
// - enable or lock enables; lock holds till reset
// - clearing enable without lock disables watchdog
// - reset defaults: divide twelve, zero bytes
// - timeout is 256 times offset plus remainder
// - idle bit suspends counting during processor idle
// - system clock is oscillator divided by 128
// - low compare write clears, high sets comparator enable
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module ca_watchdog
  import ca_wdt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_idle,
  input  wire logic        ext_count_clk,
  output logic             watchdog_reset,
  output logic             irq
);

  typedef struct packed {
    bus_state_t  wst;
    bus_state_t  rst;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic        wr_err;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    mode_t       mode;
    logic        run_sw;
    logic        ovf_flag;
    logic        module_five_match_flag;
    logic [7:0]  cnt_lo;
    logic [7:0]  cnt_hi;
    logic [7:0]  m5_mode;
    logic [7:0]  m5_lo;
    logic [7:0]  m5_hi;
    logic        wd_rst;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mk;
    logic        idle_s1;
    logic        idle_s2;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic   tick;
  logic   wd_on;
  logic   running;
  logic   count_en;
  logic   lo_ovf;
  logic   do_wr;
  logic   wr_ok;
  logic   wd_fire;
  logic   ccf_set;
  logic [IRQ_W-1:0] ev;
  logic [7:0] wb;

  ca_tick_gen u_tick (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_sel  (st_q.mode.clk_sel),
    .ext_tick (ext_count_clk),
    .tick     (tick)
  );

  // lock alone keeps the watchdog on
  assign wd_on    = st_q.mode.wd_enable | st_q.mode.wd_lock;
  assign running  = st_q.run_sw | wd_on;
  // idle input passes two flops first
  assign count_en = running & tick & ~(st_q.mode.idle_susp & st_q.idle_s2);
  assign lo_ovf   = count_en & (st_q.cnt_lo == BYTE_MAX);

  assign s_axi_awready = (st_q.wst == BUS_IDLE) & ~st_q.aw_got;
  assign s_axi_wready  = (st_q.wst == BUS_IDLE) & ~st_q.w_got;
  assign s_axi_bvalid  = (st_q.wst == BUS_RESP);
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = (st_q.rst == BUS_IDLE);
  assign s_axi_rvalid  = (st_q.rst == BUS_RESP);
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign watchdog_reset = st_q.wd_rst;
  assign irq           = |(st_q.irq_st & st_q.irq_mk);

  always_comb begin
    st_d         = st_q;
    st_d.idle_s1 = cpu_idle;
    st_d.idle_s2 = st_q.idle_s1;
    st_d.wd_rst  = 1'b0;
    do_wr        = 1'b0;
    wr_ok        = 1'b0;
    wd_fire      = 1'b0;
    ccf_set      = 1'b0;
    wb           = st_q.wdata[7:0];

    // write channel: address and data taken in either order
    case (st_q.wst)
      BUS_IDLE: begin
        if (s_axi_awvalid & s_axi_awready) begin
          st_d.aw_got  = 1'b1;
          st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          st_d.w_got = 1'b1;
          st_d.wdata = s_axi_wdata;
          st_d.wr_err = ~s_axi_wstrb[0];
        end
        if (st_q.aw_got & st_q.w_got) begin
          do_wr      = ~st_q.wr_err;
          st_d.aw_got = 1'b0;
          st_d.w_got  = 1'b0;
          st_d.wst   = BUS_RESP;
        end
      end
      BUS_RESP: begin
        if (s_axi_bready) begin
          st_d.wst = BUS_IDLE;
        end
      end
      default: st_d.wst = BUS_IDLE;
    endcase

    // counter advance
    if (count_en) begin
      st_d.cnt_lo = st_q.cnt_lo + 8'h01;
      if (lo_ovf) begin
        st_d.cnt_hi   = st_q.cnt_hi + 8'h01;
        st_d.ovf_flag = 1'b1;
      end
    end

    // normal compare of module five when not watchdog
    if (!wd_on && st_q.m5_mode[M5_CMP_EN_BIT] && st_q.m5_mode[M5_MAT_BIT] && count_en &&
        st_q.cnt_lo == st_q.m5_lo && st_q.cnt_hi == st_q.m5_hi) begin
      ccf_set = 1'b1;
    end

    // watchdog match at low overflow
    if (wd_on && lo_ovf && st_q.m5_hi == st_q.cnt_hi) begin
      wd_fire = 1'b1;
    end

    if (do_wr) begin
      wr_ok = 1'b1;
      case (st_q.aw_addr)
        OFF_CTRL: begin
          // run bit latch still records software intent
          st_d.run_sw   = wb[CTRL_RUN_BIT];
          st_d.ovf_flag = wb[CTRL_OVF_BIT] | st_d.ovf_flag;
          if (!wb[CTRL_OVF_BIT] && !lo_ovf) begin
            st_d.ovf_flag = 1'b0;
          end
          st_d.module_five_match_flag = wb[CTRL_CCF_BIT];
          if (wd_on && wb[CTRL_CCF_BIT]) begin
            wd_fire = 1'b1;
          end
        end
        OFF_MODE: begin
          if (!wd_on) begin
            st_d.mode.clk_sel   = wb[MODE_SEL_MSB:MODE_SEL_LSB];
            st_d.mode.idle_susp = wb[MODE_IDLE_BIT];
          end
          // lock is set-only until reset
          st_d.mode.wd_lock   = st_q.mode.wd_lock | wb[MODE_LCK_BIT];
          st_d.mode.wd_enable = wb[MODE_WDE_BIT];
        end
        OFF_CNT_LO: begin
          if (!wd_on) begin
            st_d.cnt_lo = wb;
          end
        end
        OFF_CNT_HI: begin
          if (!wd_on) begin
            st_d.cnt_hi = wb;
          end
        end
        OFF_M5_MOD: begin
          if (!wd_on) begin
            st_d.m5_mode = wb;
          end
        end
        OFF_M5_LO: begin
          st_d.m5_lo = wb;
          st_d.m5_mode[M5_CMP_EN_BIT] = 1'b0;
        end
        OFF_M5_HI: begin
          if (wd_on) begin
            // refresh: written value discarded
            st_d.m5_hi = st_q.cnt_hi + st_q.m5_lo;
          end else begin
            st_d.m5_hi = wb;
          end
          st_d.m5_mode[M5_CMP_EN_BIT] = 1'b1;
        end
        OFF_IRQ_ST: st_d.irq_st = st_q.irq_st & ~wb[IRQ_W-1:0];
        OFF_IRQ_MK: st_d.irq_mk = wb[IRQ_W-1:0];
        default:    wr_ok = 1'b0;
      endcase
    end

    // hardware set wins over software clear
    if (ccf_set) begin
      st_d.module_five_match_flag = 1'b1;
    end
    if (lo_ovf) begin
      st_d.ovf_flag = 1'b1;
    end
    // module five held in software timer while watchdog on
    if (wd_on && !(do_wr && st_q.aw_addr == OFF_MODE && !wb[MODE_WDE_BIT] &&
                  !st_q.mode.wd_lock)) begin
      st_d.m5_mode = st_d.m5_mode | M5_SW_TIMER;
    end
    // single-cycle reset request pulse
    st_d.wd_rst = wd_fire;

    ev = '0;
    ev[IRQ_OVF] = lo_ovf;
    ev[IRQ_WDT] = wd_fire;
    st_d.irq_st = st_d.irq_st | ev;

    if (st_q.wst == BUS_IDLE && st_q.aw_got && st_q.w_got) begin
      st_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // read channel
    case (st_q.rst)
      BUS_IDLE: begin
        if (s_axi_arvalid) begin
          st_d.rst   = BUS_RESP;
          st_d.rresp = RESP_OKAY;
          st_d.rdata = '0;
          case (s_axi_araddr)
            OFF_CTRL: begin
              st_d.rdata[CTRL_OVF_BIT] = st_q.ovf_flag;
              st_d.rdata[CTRL_RUN_BIT] = st_q.run_sw;
              st_d.rdata[CTRL_CCF_BIT] = st_q.module_five_match_flag;
            end
            OFF_MODE: begin
              st_d.rdata[MODE_IDLE_BIT] = st_q.mode.idle_susp;
              st_d.rdata[MODE_WDE_BIT]  = st_q.mode.wd_enable;
              st_d.rdata[MODE_LCK_BIT]  = st_q.mode.wd_lock;
              st_d.rdata[MODE_SEL_MSB:MODE_SEL_LSB] = st_q.mode.clk_sel;
            end
            OFF_CNT_LO: st_d.rdata[7:0] = st_q.cnt_lo;
            OFF_CNT_HI: st_d.rdata[7:0] = st_q.cnt_hi;
            OFF_M5_MOD: st_d.rdata[7:0] = st_q.m5_mode;
            OFF_M5_LO:  st_d.rdata[7:0] = st_q.m5_lo;
            OFF_M5_HI:  st_d.rdata[7:0] = st_q.m5_hi;
            OFF_IRQ_ST: st_d.rdata[IRQ_W-1:0] = st_q.irq_st;
            OFF_IRQ_MK: st_d.rdata[IRQ_W-1:0] = st_q.irq_mk;
            default:    st_d.rresp = RESP_SLVERR;
          endcase
        end
      end
      BUS_RESP: begin
        if (s_axi_rready) begin
          st_d.rst = BUS_IDLE;
        end
      end
      default: st_d.rst = BUS_IDLE;
    endcase
  end

  // reset leaves watchdog on, divide-by-twelve, zero bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q                <= '0;
      st_q.wst            <= BUS_IDLE;
      st_q.rst            <= BUS_IDLE;
      st_q.mode.clk_sel   <= SEL_DIV12;
      st_q.mode.wd_enable <= 1'b1;
      st_q.cnt_lo         <= BYTE_ZERO;
      st_q.m5_lo          <= BYTE_ZERO;
      st_q.m5_mode        <= M5_SW_TIMER;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : ca_watchdog

// ==== ca_watchdog_chk.sv ====
// port assertions for the counter-array watchdog
`timescale 1ns/10ps
module ca_watchdog_chk
  import ca_wdt_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        watchdog_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic        en_q;
  logic        lock_q;
  logic        clean_q;
  logic        fired_q;
  logic [15:0] cyc_q;
  logic        wr;
  // shadow of enable; only valid when address and data are taken together
  // a write without byte lane zero has no effect, so it is not counted
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
              s_axi_wstrb[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q    <= 1'b1;
      lock_q  <= 1'b0;
      clean_q <= 1'b1;
      fired_q <= 1'b0;
      cyc_q   <= 16'h0000;
    end else begin
      if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h0001;
      if (wr) clean_q <= 1'b0;
      if (watchdog_reset) fired_q <= 1'b1;
      if (wr && s_axi_awaddr == OFF_MODE) begin
        en_q   <= lock_q | s_axi_wdata[MODE_WDE_BIT] | s_axi_wdata[MODE_LCK_BIT];
        lock_q <= lock_q | s_axi_wdata[MODE_LCK_BIT];
      end
    end
  end
  property p_pulse; watchdog_reset |=> !watchdog_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset request wider than one cycle");
  property p_force;
    wr && s_axi_awaddr == OFF_CTRL && s_axi_wdata[CTRL_CCF_BIT] && en_q |-> ##[2:4] watchdog_reset;
  endproperty
  a_force: assert property (p_force) else $error("forced reset missing");
  property p_off; !en_q && !$past(en_q, 4) |-> !watchdog_reset; endproperty
  a_off: assert property (p_off) else $error("reset while disabled");
  property p_dflt; clean_q && watchdog_reset |-> cyc_q >= 16'h0bfc && cyc_q <= 16'h0c08; endproperty
  a_dflt: assert property (p_dflt) else $error("default timeout off");
  property p_fire; clean_q && cyc_q == 16'h0c10 |-> fired_q; endproperty
  a_fire: assert property (p_fire) else $error("default timeout never fired");
  property p_blat; wr |-> ##2 s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read response late");
  property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bone: assert property (p_bone) else $error("extra write response");
  property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rone: assert property (p_rone) else $error("extra read response");
endmodule : ca_watchdog_chk

// ==== ca_wdt_pkg.sv ====
// constants, register map and state types for the counter-array watchdog
package ca_wdt_pkg;

  // register byte addresses (one aligned word each)
  localparam logic [7:0] OFF_CTRL   = 8'h00; // counter control: run, match flag
  localparam logic [7:0] OFF_MODE   = 8'h04; // counter mode: enable, lock, select, idle
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] OFF_M5_MOD = 8'h10;
  localparam logic [7:0] OFF_M5_LO  = 8'h14;
  localparam logic [7:0] OFF_M5_HI  = 8'h18;
  localparam logic [7:0] OFF_IRQ_ST = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MK = 8'h20;

  // control register fields
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_CCF_BIT = 5;
  // mode register fields
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDE_BIT  = 6;
  localparam int MODE_LCK_BIT  = 5;
  localparam int MODE_SEL_LSB  = 1;
  localparam int MODE_SEL_MSB  = 3;
  // module five mode register fields
  localparam int M5_CMP_EN_BIT = 6;
  localparam int M5_MAT_BIT    = 3;
  localparam logic [7:0] M5_SW_TIMER = 8'h48;

  // interrupt status bits
  localparam int IRQ_OVF = 0;
  localparam int IRQ_WDT = 1;
  localparam int IRQ_W   = 2;

  // clock source select values
  localparam logic [2:0] SEL_DIV12 = 3'h0;
  localparam logic [2:0] SEL_DIV4  = 3'h1;
  localparam logic [2:0] SEL_EXT   = 3'h2;
  localparam logic [2:0] SEL_SYS   = 3'h4;

  // prescale counts for the divided sources
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [7:0] BYTE_MAX   = 8'hff;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // system clock reset divisor from the internal oscillator
  localparam int SYS_RESET_DIV = 128;
  localparam int DEF_TIMEOUT_COUNTER_CLKS = 256;
  localparam int DEF_TIMEOUT_SYS_CLKS = 3072;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RESP
  } bus_state_t;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic       idle_susp;
    logic       wd_enable;
    logic       wd_lock;
  } mode_t;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

endpackage : ca_wdt_pkg

// ==== counter_array_watchdog_mode_bench.sv ====
// self-checking bench for the counter-array watchdog
`timescale 1ns/10ps
module counter_array_watchdog_mode_bench
  import ca_wdt_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cpu_idle, ext_count_clk, watchdog_reset, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] cyc;
  int          err_count, total_checks;

  ca_watchdog u_dut (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .cpu_idle       (cpu_idle),
    .ext_count_clk  (ext_count_clk),
    .watchdog_reset (watchdog_reset),
    .irq            (irq)
  );
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= aresetn ? cyc + 16'h0001 : 16'h0000;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) ad = 1'b1;
      if (s_axi_wready) wd = 1'b1;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end while (!(ad && wd));
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic rst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  // counts edges until the one-cycle request shows, at most n
  task automatic pulse_wait(input int n, output int c);
    c = 0;
    while (c < n && watchdog_reset !== 1'b1) begin
      @(posedge aclk);
      c++;
    end
  endtask : pulse_wait

  task automatic t_defaults;
    int c;
    rst();
    rdr(OFF_MODE);
    chk(rd, 32'h00000040);
    rdr(OFF_M5_MOD);
    chk(rd, {24'h000000, M5_SW_TIMER});
    rdr(OFF_CTRL);
    chk(rd, 32'h00000000);
    rdr(8'h24);
    chk(32'(rsp), 32'(RESP_SLVERR));
    pulse_wait(3300, c);
    chk(32'(cyc >= 16'h0bfc && cyc <= 16'h0c0a), 32'h1);
    rdr(OFF_IRQ_ST);
    chk(rd & 32'h2, 32'h2);
    chk(32'(irq), 32'h0);
    wr(OFF_IRQ_MK, 32'h2);
    #1 chk(32'(irq), 32'h1);
    wr(OFF_IRQ_ST, 32'h2);
    #1 chk(32'(irq), 32'h0);
  endtask : t_defaults

  task automatic t_locks;
    int c;
    logic [31:0] v;
    rst();
    wr(OFF_MODE, 32'h42);
    rdr(OFF_MODE);
    chk(rd, 32'h00000040);
    wr(OFF_M5_MOD, 32'h00);
    rdr(OFF_M5_MOD);
    chk(rd, {24'h000000, M5_SW_TIMER});
    wr(OFF_CNT_HI, 32'h77);
    rdr(OFF_CNT_HI);
    chk(rd, 32'h00000000);
    wr(OFF_CNT_LO, 32'h00, 4'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(OFF_M5_LO, 32'h03);
    wr(OFF_M5_HI, 32'haa);
    rdr(OFF_M5_HI);
    chk(rd, 32'h00000003);
    wr(OFF_CTRL, 32'h40);
    rdr(OFF_CTRL);
    chk(rd & 32'h40, 32'h40);
    wr(OFF_CTRL, 32'h00);
    rdr(OFF_CNT_LO);
    v = rd;
    repeat (36) @(posedge aclk);
    rdr(OFF_CNT_LO);
    chk(32'(rd - v >= 32'd3), 32'h1);
    wr(OFF_CTRL, 32'h20);
    pulse_wait(8, c);
    chk(32'(c < 8), 32'h1);
  endtask : t_locks

  task automatic t_disable;
    int c;
    rst();
    wr(OFF_MODE, 32'h00);
    wr(OFF_MODE, 32'h02);
    rdr(OFF_MODE);
    chk(rd, 32'h00000002);
    wr(OFF_M5_MOD, 32'h00);
    rdr(OFF_M5_MOD);
    chk(rd, 32'h00000000);
    wr(OFF_M5_HI, 32'h55);
    rdr(OFF_M5_MOD);
    chk(rd, 32'h00000040);
    rdr(OFF_M5_HI);
    chk(rd, 32'h00000055);
    wr(OFF_M5_LO, 32'h00);
    rdr(OFF_M5_MOD);
    chk(rd, 32'h00000000);
    // external source: count four synchronised rising edges
    wr(OFF_MODE, 32'h04);
    wr(OFF_CNT_LO, 32'h10);
    wr(OFF_CTRL, 32'h40);
    repeat (4) begin
      ext_count_clk <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_count_clk <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    rdr(OFF_CNT_LO);
    chk(rd, 32'h00000014);
    wr(OFF_CTRL, 32'h20);
    pulse_wait(3500, c);
    chk(32'(c), 32'd3500);
  endtask : t_disable

  task automatic t_lock;
    int c;
    rst();
    wr(OFF_MODE, 32'h20);
    wr(OFF_MODE, 32'h00);
    wr(OFF_CTRL, 32'h20);
    pulse_wait(8, c);
    chk(32'(c < 8), 32'h1);
  endtask : t_lock

  // idle holds the count, so the timeout starts from a known low byte
  task automatic t_config;
    int c;
    rst();
    cpu_idle <= 1'b1;
    wr(OFF_MODE, 32'h00);
    wr(OFF_MODE, 32'h08);
    wr(OFF_M5_LO, 32'h01);
    wr(OFF_MODE, 32'h88);
    wr(OFF_MODE, 32'hc8);
    wr(OFF_M5_HI, 32'h00);
    rdr(OFF_M5_HI);
    chk(rd, 32'h00000001);
    pulse_wait(600, c);
    chk(32'(c), 32'd600);
    cpu_idle <= 1'b0;
    pulse_wait(700, c);
    chk(32'(c >= 512 && c <= 518), 32'h1);
  endtask : t_config

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_idle, ext_count_clk, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    t_defaults();
    t_locks();
    t_disable();
    t_lock();
    t_config();
    close_out();
  end

  // whole run needs about 8000 cycles
  initial begin
    #500us;
    err_count++;
    $display("unexpected at %0t: run hung", $time);
    close_out();
  end
endmodule : counter_array_watchdog_mode_bench

bind ca_watchdog ca_watchdog_chk u_chk (
  .aclk           (aclk),
  .aresetn        (aresetn),
  .s_axi_awaddr   (s_axi_awaddr),
  .s_axi_awvalid  (s_axi_awvalid),
  .s_axi_awready  (s_axi_awready),
  .s_axi_wdata    (s_axi_wdata),
  .s_axi_wstrb    (s_axi_wstrb),
  .s_axi_wvalid   (s_axi_wvalid),
  .s_axi_wready   (s_axi_wready),
  .s_axi_bvalid   (s_axi_bvalid),
  .s_axi_bready   (s_axi_bready),
  .s_axi_arvalid  (s_axi_arvalid),
  .s_axi_arready  (s_axi_arready),
  .s_axi_rvalid   (s_axi_rvalid),
  .s_axi_rready   (s_axi_rready),
  .watchdog_reset (watchdog_reset)
);
